// file: drc_defines.svh
`ifndef DRC_DEFINES_SVH
`define DRC_DEFINES_SVH
`define DRC_WORD_BITS     24
`define DRC_CNT_W         5
`define DRC_CNT_LAST      5'h17
`define DRC_CODE_W        12
`define DRC_CTRL_LO       16
`define DRC_CTRL_HI       23
`define DRC_DATA_LO       4
`define DRC_DATA_HI       15
`define DRC_CMD_REF_OFF   20'h0_1200
`define DRC_CMD_REF_AUTO  20'h0_1000
`define DRC_CMD_REF_ON    20'h0_1100
`define DRC_SIGN_FLIP     12'h800
`define DRC_BIT_PD        16
`endif

// file: drc_pkg.sv
package drc_pkg;
  // reference mode, one-hot
  typedef enum logic [2:0] {
    DRC_REF_AUTO = 3'b001,
    DRC_REF_OFF  = 3'b010,
    DRC_REF_ON   = 3'b100
  } drc_ref_mode_e;
endpackage : drc_pkg

// file: drc_word_if.sv
interface drc_word_if;
  logic        word_valid;
  logic [23:0] word;
  modport rx (output word_valid, output word);
  modport top (input word_valid, input word);
endinterface : drc_word_if

// file: drc_serial_rx.sv
`include "drc_defines.svh"

module drc_serial_rx (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic frame_sync_n,
  input wire logic serial_clk,
  input wire logic serial_data,
  drc_word_if.rx   wif
);
  logic [2:0]             fs_sync_r;
  logic [2:0]             sc_sync_r;
  logic [2:0]             sd_sync_r;
  logic [`DRC_CNT_W-1:0]  cnt_r;
  logic [23:0]            shift_r;
  logic                   locked_r;
  logic                   fs_low;
  logic                   sc_fall;

  // three-stage synchronisers, second and third stages compared
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      fs_sync_r <= 3'h7;
      sc_sync_r <= 3'h7; // idle level of the serial clock, no false edge
      sd_sync_r <= 3'h0;
    end else begin
      fs_sync_r <= {fs_sync_r[1:0], frame_sync_n};
      sc_sync_r <= {sc_sync_r[1:0], serial_clk};
      sd_sync_r <= {sd_sync_r[1:0], serial_data};
    end
  end

  assign fs_low       = !fs_sync_r[1] && !fs_sync_r[2];
  assign sc_fall      = !sc_sync_r[1] && sc_sync_r[2];

  // shift in msb first on falling serial clock, lock at 24th
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      cnt_r    <= '0;
      shift_r  <= '0;
      locked_r <= 1'b0;
    end else if (!fs_low) begin
      cnt_r    <= '0;
      locked_r <= 1'b0;
    end else if (sc_fall && !locked_r) begin
      shift_r <= {shift_r[22:0], sd_sync_r[2]};
      if (cnt_r == `DRC_CNT_LAST) begin
        cnt_r    <= '0;
        locked_r <= 1'b1;
      end else begin
        cnt_r <= cnt_r + 1'b1;
      end
    end
  end

  // one-cycle strobe when the word locks
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      wif.word_valid <= 1'b0;
      wif.word       <= '0;
    end else begin
      wif.word_valid <= fs_low && sc_fall && !locked_r && (cnt_r == `DRC_CNT_LAST);
      wif.word       <= {shift_r[22:0], sd_sync_r[2]};
    end
  end
endmodule : drc_serial_rx

// file: drc_ref_ctrl.sv
`include "drc_defines.svh"

module drc_ref_ctrl
  import drc_pkg::*;
#(
  parameter int CODE_W = `DRC_CODE_W,
  parameter int NCH    = 4
) (
  input  wire logic              clk,
  input  wire logic              reset_n,
  input  wire logic              frame_sync_n,
  input  wire logic              serial_clk,
  input  wire logic              serial_data,
  input  wire logic [NCH-1:0]    channel_powered_down,
  input  wire logic              twos_complement_code,
  input  wire logic [CODE_W-1:0] channel_code_in,
  output logic                   reference_enable,
  output logic                   reference_output_pin_oe,
  output logic                   use_external_reference,
  output logic [1:0]             reference_mode,
  output logic                   powerdown_select_bit,
  output logic [23:0]            last_command,
  output logic                   command_strobe,
  output logic [CODE_W-1:0]      channel_code_binary
);
  drc_word_if     wif ();
  drc_ref_mode_e  mode_r;
  drc_ref_mode_e  mode_nxt;
  logic [19:0]    cmd_bits;
  logic           ref_on;

  ////////////////////////////////////////////////////////////////////
  // serial receiver
  drc_serial_rx u_rx (
    .clk          (clk),
    .reset_n      (reset_n),
    .frame_sync_n (frame_sync_n),
    .serial_clk   (serial_clk),
    .serial_data  (serial_data),
    .wif          (wif)
  );

  // map signed code to straight binary by flipping the sign bit
  function automatic logic [CODE_W-1:0] to_binary(input logic [CODE_W-1:0] c,
                                                   input logic tc);
    to_binary = tc ? (c ^ CODE_W'(`DRC_SIGN_FLIP)) : c;
  endfunction : to_binary

  ////////////////////////////////////////////////////////////////////
  // control and data bits, low nibble dropped
  assign cmd_bits = wif.word[`DRC_CTRL_HI:`DRC_DATA_LO];

  // next reference mode from decoded command
  always_comb begin
    mode_nxt = mode_r;
    if (wif.word_valid && wif.word[`DRC_BIT_PD]) begin
      case (cmd_bits)
        `DRC_CMD_REF_OFF:  mode_nxt = DRC_REF_OFF;
        `DRC_CMD_REF_AUTO: mode_nxt = DRC_REF_AUTO;
        `DRC_CMD_REF_ON:   mode_nxt = DRC_REF_ON;
        default:           mode_nxt = mode_r;
      endcase
    end
  end

  // mode state, reset to automatic
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      mode_r <= DRC_REF_AUTO;
    end else begin
      mode_r <= mode_nxt;
    end
  end

  // reference power per mode
  always_comb begin
    case (mode_r)
      DRC_REF_AUTO: ref_on = ~&channel_powered_down;
      DRC_REF_OFF:  ref_on = 1'b0;
      DRC_REF_ON:   ref_on = 1'b1;
      default:      ref_on = 1'b1;
    endcase
  end

  // registered outputs
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      reference_enable        <= 1'b1;
      reference_output_pin_oe <= 1'b1;
      use_external_reference  <= 1'b0;
      reference_mode          <= 2'h0;
      powerdown_select_bit    <= 1'b0;
      last_command            <= '0;
      command_strobe          <= 1'b0;
      channel_code_binary     <= '0;
    end else begin
      reference_enable        <= ref_on;
      reference_output_pin_oe <= (mode_r != DRC_REF_OFF);
      use_external_reference  <= (mode_r == DRC_REF_OFF);
      reference_mode          <= (mode_r == DRC_REF_OFF) ? 2'h1 :
                                 (mode_r == DRC_REF_ON) ? 2'h2 : 2'h0;
      command_strobe          <= wif.word_valid;
      if (wif.word_valid) begin
        last_command         <= wif.word;
        powerdown_select_bit <= wif.word[`DRC_BIT_PD];
      end
      channel_code_binary     <= to_binary(channel_code_in, twos_complement_code);
    end
  end
endmodule : drc_ref_ctrl

// file: drc_ref_ctrl_chk.sv
module drc_ref_ctrl_chk #(
  parameter int CODE_W = 12,
  parameter int NCH    = 4
) (
  input wire logic [0:0]        clk,
  input wire logic [0:0]        reset_n,
  input wire logic [NCH-1:0]    channel_powered_down,
  input wire logic [0:0]        twos_complement_code,
  input wire logic [CODE_W-1:0] channel_code_in,
  input wire logic [0:0]        reference_enable,
  input wire logic [0:0]        reference_output_pin_oe,
  input wire logic [0:0]        use_external_reference,
  input wire logic [1:0]        reference_mode,
  input wire logic [0:0]        command_strobe,
  input wire logic [CODE_W-1:0] channel_code_binary
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge clk); endclocking
  default disable iff (!reset_n);
  // automatic mode held steady with all channels down or one up
  sequence s_all_down; (reference_mode == 2'd0 && &channel_powered_down)[*3]; endsequence
  sequence s_one_up; (reference_mode == 2'd0 && !(&channel_powered_down))[*3]; endsequence
  chk_off_floats: assert property (reference_mode == 2'd1
    |-> !reference_output_pin_oe && use_external_reference) else $error("pin driven while off");
  chk_ext_only_off: assert property (reference_mode != 2'd1
    |-> !use_external_reference) else $error("external reference outside off mode");
  chk_on_enabled: assert property (reference_mode == 2'd2
    |-> reference_enable) else $error("reference down in always-on mode");
  chk_auto_down: assert property (s_all_down |-> !reference_enable)
    else $error("reference up with all channels down");
  chk_auto_up: assert property (s_one_up |-> reference_enable)
    else $error("reference down with a channel up");
  chk_code_map: assert property (1'b1 |=> channel_code_binary ==
    ($past(channel_code_in) ^ {$past(twos_complement_code), {(CODE_W-1){1'b0}}}))
    else $error("code conversion wrong");
  chk_strobe_pulse: assert property (command_strobe |=> !command_strobe)
    else $error("strobe longer than one cycle");
  chk_mode_cause: assert property ($changed(reference_mode) |-> $past(command_strobe))
    else $error("mode changed without a word");
endmodule : drc_ref_ctrl_chk
bind drc_ref_ctrl drc_ref_ctrl_chk #(.CODE_W(CODE_W), .NCH(NCH)) drc_ref_ctrl_chk_i (.clk,
  .reset_n, .channel_powered_down, .twos_complement_code, .channel_code_in, .reference_enable,
  .reference_output_pin_oe, .use_external_reference, .reference_mode, .command_strobe,
  .channel_code_binary);

// file: drc_host_model.sv
module drc_host_model (
  output logic frame_sync_n,
  output logic serial_clk,
  output logic serial_data
);
  timeunit 1ns;
  timeprecision 1ps;
  // idle: frame high, serial clock parked high
  initial begin
    frame_sync_n = 1'b1;
    serial_clk = 1'b1;
    serial_data = 1'b0;
  end
  // n bits msb first, data taken on falling serial clock
  task automatic send(input logic [23:0] w, input int n);
    frame_sync_n = 1'b0;
    for (int i = 0; i < n; i++) begin
      serial_data = w[23-i];
      #160 serial_clk = 1'b0;
      #160 serial_clk = 1'b1;
    end
    #160 frame_sync_n = 1'b1;
    serial_data = ~serial_data;
    #480;
  endtask : send
endmodule : drc_host_model

// file: drc_ref_ctrl_tb.sv
module drc_ref_ctrl_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 0, reset_n = 0, twos_complement_code = 0, rnd = 0, rnd_d = 0;
  logic powerdown_select_bit;
  logic [23:0] last_command;
  logic [25:0] note;
  logic [3:0] channel_powered_down = 0;
  logic [11:0] channel_code_in = 0, channel_code_binary;
  logic reference_enable, reference_output_pin_oe, use_external_reference, command_strobe;
  logic [1:0] reference_mode;
  wire frame_sync_n, serial_clk, serial_data;
  int miscompares = 0, n_checks = 0, seed = 84292;
  logic [25:0] exp_q[$];
  always #20 clk = ~clk;
  drc_host_model drc_host_model_i (.frame_sync_n, .serial_clk, .serial_data);
  drc_ref_ctrl drc_ref_ctrl_i (.clk, .reset_n, .frame_sync_n, .serial_clk, .serial_data,
    .channel_powered_down, .twos_complement_code, .channel_code_in, .reference_enable,
    .reference_output_pin_oe, .use_external_reference, .reference_mode,
    .powerdown_select_bit, .last_command, .command_strobe, .channel_code_binary);
  task automatic chk(string nm, logic [23:0] e, logic [23:0] s);
    n_checks++;
    if (s !== e) begin
      miscompares++;
      $display("unexpected %s: expected %h seen %h", nm, e, s);
    end
  endtask : chk
  // whole words note the mode they should leave
  task automatic put(logic [19:0] w, int n, logic [1:0] m);
    logic [23:0] full;
    full = {w, 4'($random(seed))};
    if (n == 24) exp_q.push_back({m, full});
    drc_host_model_i.send(full, n);
  endtask : put
  task report_and_stop;
    if (miscompares == 0 && n_checks > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask : report_and_stop
  // random codes, format and channel states
  always @(posedge clk) begin
    #1;
    if (rnd_d)
      chk("code", channel_code_in ^ {twos_complement_code, 11'h000}, channel_code_binary);
    rnd_d = rnd;
    channel_code_in <= 12'($random(seed));
    twos_complement_code <= 1'($random(seed));
    if (rnd) channel_powered_down <= 4'($random(seed));
  end
  // mode compared one cycle after each strobe
  always @(posedge clk) if (command_strobe === 1'b1) begin
    note = exp_q.size() ? exp_q.pop_front() : 26'h3ff_ffff;
    chk("word", note[23:0], last_command);
    chk("select", note[16], powerdown_select_bit);
    @(posedge clk);
    #1 chk("mode", note[25:24], reference_mode);
  end
  // directed sequence
  initial begin
    repeat (8) @(posedge clk);
    #1 reset_n = 1;
    chk("enable", 1, reference_enable);
    chk("mode", 0, reference_mode);
    repeat (4) @(posedge clk);
    #1 put(20'h0_1200, 24, 2'd1);
    chk("pin_oe", 0, reference_output_pin_oe);
    put(20'h0_1000, 24, 2'd0);
    channel_powered_down = 4'hf;
    repeat (4) @(posedge clk);
    #1 chk("enable", 0, reference_enable);
    channel_powered_down = 4'hb;
    repeat (4) @(posedge clk);
    #1 chk("enable", 1, reference_enable);
    channel_powered_down = 4'hf;
    put(20'h0_1100, 24, 2'd2);
    put(20'h0_0200, 24, 2'd2);
    put(20'h0_1200, 12, 2'd1);
    chk("mode", 2, reference_mode);
    reset_n = 0;
    @(posedge clk);
    #1 reset_n = 1;
    chk("mode", 0, reference_mode);
    rnd = 1;
    repeat (300) @(posedge clk);
    chk("pending", 0, exp_q.size());
    report_and_stop;
  end
  // watchdog
  initial begin
    #200_000;
    miscompares++;
    report_and_stop;
  end
endmodule : drc_ref_ctrl_tb
